// [rtl/pmtbp_dev.sv]
// Device end of the bus port: master, target, config space, parity, interrupt
// Overview of operation
// - Master drives address in first phase
// - Burst data follows; target advances address pointer
// - Target answers only its decoded address range
// - Command code on enables during address phase
// - Byte enables select valid lanes per data
// - Little endian: enable 0 is bits 7-0
// - Big endian: enable 0 is bits 31-24
// - All phases start on bus clock rise
// - Master checks device select before trusting transfer
// - Target drives device select low on hit
// - Frame held low, released as the last phase starts
// - Target decodes only after frame falls
// - Master starts only while grant held low
// - Request driven low before expecting grant
// - Interrupt low from status, mask and enable
// - Initiator ready low only when completing
// - Word moves when both readies low
// - Target write data valid with initiator ready
// - Target ready low only when target completes
// - Parity makes ones count even
// - Parity driven for own address/data phases only
`timescale 1ns/100ps
`include "pmtbp_cfg.svh"
module pmtbp_dev #(
	parameter int MW = 16
) (
	input wire logic mclk,
	input wire logic nrst,
	pmtbp_if.dev bus,
	input wire logic m_go,
	input wire logic m_write,
	input wire logic [31:0] m_addr,
	input wire logic [3:0] m_cnt,
	input wire logic [3:0] m_be_n,
	input wire logic [31:0] m_wdata,
	output logic m_busy,
	output logic m_wtake,
	output logic m_rvalid,
	output logic [31:0] m_rdata,
	output logic m_done,
	output logic m_abort
);
	import pmtbp_pkg::*;
	localparam int AW = $clog2(MW);
	typedef struct packed {
		pmtbp_smp_s s1;
		pmtbp_smp_s s2;
		logic clk_d;
		logic frame_d;
		pmtbp_mst_e mst;
		logic [31:0] m_ptr;
		logic [3:0] m_left;
		logic m_wr;
		logic [3:0] m_be_n;
		logic [3:0] m_tmo;
		logic m_sel;
		pmtbp_tgt_e tgt;
		logic [AW-1:0] t_ptr;
		logic t_cfg;
		logic t_wr;
		pmtbp_drv_s d;
		logic req_n;
		logic inta_n;
		logic [3:0][31:0] cfg;
		logic [MW-1:0][31:0] mem;
		logic m_busy;
		logic m_wtake;
		logic m_rvalid;
		logic [31:0] m_rdata;
		logic m_done;
		logic m_abort;
	} pmtbp_dst_s;
	pmtbp_dst_s r;
	pmtbp_dst_s n;
	pmtbp_smp_s smp;
	logic tick;
	logic big;
	logic [3:0] be_map;
	logic [31:0] wd_map;
	logic [31:0] rd_map;
	logic [3:0] cmd;
	logic hit_mem;
	logic hit_cfg;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Word the target returns for a read at index i
	function automatic logic [31:0] rdw(input pmtbp_dst_s s, input logic c,
		input logic [AW-1:0] i);
		return c ? s.cfg[i[1:0]] : s.mem[i];
	endfunction

	// Raw bus lines; all pass two flops before use
	always_comb begin
		smp.clk = bus.bus_clk;
		smp.ad = bus.ad;
		smp.cbe_n = bus.cbe_n;
		smp.frame_n = bus.frame_n;
		smp.irdy_n = bus.irdy_n;
		smp.trdy_n = bus.trdy_n;
		smp.devsel_n = bus.devsel_n;
		smp.gnt_n = bus.gnt_n;
		smp.idsel = bus.idsel;
	end

	// Rising bus clock edge seen on the synchronised copy
	assign tick = r.s2.clk & ~r.clk_d;
	assign big = r.cfg[`PMTBP_CFG_CTRL][`PMTBP_CTRL_BIG];
	assign cmd = r.s2.cbe_n;
	assign hit_mem = (cmd == `PMTBP_CMD_MRD || cmd == `PMTBP_CMD_MWR)
		&& r.s2.ad[31:AW+2] == r.cfg[`PMTBP_CFG_BASE][31:AW+2];
	assign hit_cfg = (cmd == `PMTBP_CMD_CRD || cmd == `PMTBP_CMD_CWR) && r.s2.idsel;

	// Outgoing master data and enables in bus order
	pmtbp_lane u_out (
		.big(big),
		.be_i(r.m_be_n),
		.d_i(m_wdata),
		.be_o(be_map),
		.d_o(wd_map)
	);
	// Incoming master read data back to user order
	pmtbp_lane u_in (
		.big(big),
		.be_i(r.m_be_n),
		.d_i(r.s2.ad),
		.be_o(),
		.d_o(rd_map)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] set;
		logic [31:0] clr;
		set = '0;
		clr = '0;
		n = r;
		n.s1 = smp;
		n.s2 = r.s1;
		n.clk_d = r.s2.clk;
		n.m_wtake = 1'b0;
		n.m_rvalid = 1'b0;
		n.m_done = 1'b0;
		n.m_abort = 1'b0;
		// Order accepted when the master is idle with no request pending and a nonzero count
		if (r.mst == M_IDLE && r.req_n && m_go && m_cnt != '0) begin
			n.m_ptr = m_addr;
			n.m_left = m_cnt;
			n.m_wr = m_write;
			n.m_be_n = m_be_n;
			n.req_n = 1'b0;
		end
		if (tick) begin
			n.frame_d = r.s2.frame_n;
			// Parity over what was on the lines during the phase just ended
			n.d.par = ^{r.s2.ad, r.s2.cbe_n};
			n.d.par_oe = r.d.ad_oe;
			case (r.mst)
				M_IDLE: begin
					if (!r.req_n && !r.s2.gnt_n && r.s2.frame_n && r.s2.irdy_n
						&& r.tgt == T_IDLE) begin
						n.mst = M_ADDR;
						n.req_n = 1'b1;
						n.d.frame_n = 1'b0;
						n.d.frame_oe = 1'b1;
						n.d.ad = r.m_ptr;
						n.d.ad_oe = 1'b1;
						n.d.cbe_n = r.m_wr ? `PMTBP_CMD_MWR : `PMTBP_CMD_MRD;
						n.d.cbe_oe = 1'b1;
					end
				end
				M_ADDR: begin
					n.mst = M_DATA;
					n.d.cbe_n = be_map;
					n.d.irdy_n = 1'b0;
					n.d.irdy_oe = 1'b1;
					n.d.frame_n = (r.m_left == 4'h1);
					n.d.ad = wd_map;
					n.d.ad_oe = r.m_wr;
					n.m_wtake = r.m_wr;
					n.m_tmo = '0;
					n.m_sel = 1'b0;
				end
				M_DATA: begin
					if (!r.s2.devsel_n) n.m_sel = 1'b1;
					if (!r.s2.irdy_n && !r.s2.trdy_n && !r.s2.devsel_n) begin
						n.m_rdata = rd_map;
						n.m_rvalid = !r.m_wr;
						n.m_ptr = r.m_ptr + `PMTBP_WSTEP;
						n.m_left = r.m_left - 4'h1;
						if (r.m_left == 4'h1) begin
							n.mst = M_TURN;
							n.d.irdy_n = 1'b1;
							n.d.ad_oe = 1'b0;
							n.m_done = 1'b1;
							set[`PMTBP_ST_MDONE] = 1'b1;
						end else begin
							n.d.frame_n = (r.m_left == 4'h2);
							n.d.ad = wd_map;
							n.m_wtake = r.m_wr;
						end
					end else if (!r.m_sel && r.m_tmo == `PMTBP_DSEL_TMO) begin
						// Nobody claimed the address: master abort
						n.mst = M_TURN;
						n.d.frame_n = 1'b1;
						n.d.irdy_n = 1'b1;
						n.d.ad_oe = 1'b0;
						n.m_abort = 1'b1;
						set[`PMTBP_ST_MABT] = 1'b1;
					end else if (!r.m_sel) begin
						n.m_tmo = r.m_tmo + 4'h1;
					end
				end
				M_TURN: begin
					n.mst = M_IDLE;
					n.d.frame_oe = 1'b0;
					n.d.irdy_oe = 1'b0;
					n.d.cbe_oe = 1'b0;
				end
				default: n.mst = M_IDLE;
			endcase
			case (r.tgt)
				T_IDLE: begin
					// Claim only on the frame's falling edge, own master idle
					if (r.frame_d && !r.s2.frame_n && r.mst == M_IDLE
						&& (hit_mem || hit_cfg)) begin
						n.tgt = T_ACT;
						n.t_cfg = hit_cfg;
						n.t_wr = cmd[`PMTBP_CMD_WBIT];
						n.t_ptr = r.s2.ad[AW+1:2];
						n.d.devsel_n = 1'b0;
						n.d.devsel_oe = 1'b1;
						n.d.trdy_n = 1'b0;
						n.d.trdy_oe = 1'b1;
						n.d.ad = rdw(r, hit_cfg, r.s2.ad[AW+1:2]);
						n.d.ad_oe = !cmd[`PMTBP_CMD_WBIT];
					end
				end
				T_ACT: begin
					if (!r.s2.irdy_n) begin
						if (r.t_wr && r.t_cfg && r.t_ptr[1:0] == `PMTBP_CFG_STAT)
							clr = pmtbp_merge('0, r.s2.ad, r.s2.cbe_n);
						else if (r.t_wr && r.t_cfg)
							n.cfg[r.t_ptr[1:0]] = pmtbp_merge(r.cfg[r.t_ptr[1:0]],
								r.s2.ad, r.s2.cbe_n);
						else if (r.t_wr)
							n.mem[r.t_ptr] = pmtbp_merge(r.mem[r.t_ptr], r.s2.ad,
								r.s2.cbe_n);
						n.t_ptr = r.t_ptr + 1'b1;
						n.d.ad = rdw(r, r.t_cfg, r.t_ptr + 1'b1);
						if (r.s2.frame_n) begin
							n.tgt = T_TURN;
							n.d.devsel_n = 1'b1;
							n.d.trdy_n = 1'b1;
							n.d.ad_oe = 1'b0;
							// Config writes excluded, else a status clear would set it again
							set[`PMTBP_ST_TWR] = r.t_wr && !r.t_cfg;
						end
					end
				end
				T_TURN: begin
					n.tgt = T_IDLE;
					n.d.devsel_oe = 1'b0;
					n.d.trdy_oe = 1'b0;
				end
				default: n.tgt = T_IDLE;
			endcase
		end
		// Sticky status; a new event beats a clear in the same cycle
		n.cfg[`PMTBP_CFG_STAT] = (r.cfg[`PMTBP_CFG_STAT] & ~clr) | set;
		n.inta_n = !(r.cfg[`PMTBP_CFG_CTRL][`PMTBP_CTRL_IEN]
			&& |(r.cfg[`PMTBP_CFG_STAT] & r.cfg[`PMTBP_CFG_MASK]));
		n.m_busy = (n.mst != M_IDLE) || !n.req_n;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.req_n <= 1'b1;
			r.inta_n <= 1'b1;
			r.cfg[`PMTBP_CFG_BASE] <= `PMTBP_BASE_RST;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state flops
	assign bus.d = r.d;
	assign bus.req_n = r.req_n;
	assign bus.inta_n = r.inta_n;
	assign m_busy = r.m_busy;
	assign m_wtake = r.m_wtake;
	assign m_rvalid = r.m_rvalid;
	assign m_rdata = r.m_rdata;
	assign m_done = r.m_done;
	assign m_abort = r.m_abort;
endmodule

// [include/pmtbp_cfg.svh]
// Constants for the bus port: commands, config layout, host registers, timing
`ifndef PMTBP_CFG_SVH
`define PMTBP_CFG_SVH
// ----------------------------------------
// Bus command codes
// ----------------------------------------
`define PMTBP_CMD_MRD 4'h6
`define PMTBP_CMD_MWR 4'h7
`define PMTBP_CMD_CRD 4'hA
`define PMTBP_CMD_CWR 4'hB
`define PMTBP_CMD_WBIT 0
// ----------------------------------------
// Device config space, word indexes
// ----------------------------------------
`define PMTBP_CFG_CTRL 2'h0
`define PMTBP_CFG_MASK 2'h1
`define PMTBP_CFG_STAT 2'h2
`define PMTBP_CFG_BASE 2'h3
`define PMTBP_CTRL_BIG 0
`define PMTBP_CTRL_IEN 1
`define PMTBP_ST_MDONE 0
`define PMTBP_ST_MABT 1
`define PMTBP_ST_TWR 2
`define PMTBP_BASE_RST 32'h1000_0000
`define PMTBP_HBASE 32'h2000_0000
`define PMTBP_WSTEP 32'h0000_0004
// ----------------------------------------
// Host register offsets and fields
// ----------------------------------------
`define PMTBP_H_ADDR 5'h00
`define PMTBP_H_WDAT 5'h04
`define PMTBP_H_CTRL 5'h08
`define PMTBP_H_STAT 5'h0C
`define PMTBP_H_RDAT 5'h10
`define PMTBP_HC_CMD 3:0
`define PMTBP_HC_BE 7:4
`define PMTBP_HC_IDS 8
`define PMTBP_HC_GO 9
// ----------------------------------------
// Timing
// ----------------------------------------
`define PMTBP_DSEL_TMO 4'h5
`define PMTBP_DIV_HALF 4'h4
`endif

// [include/pmtbp_pkg.sv]
// Shared types and helpers of the bus port
package pmtbp_pkg;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ADDR = 2'b01,
		M_DATA = 2'b10,
		M_TURN = 2'b11
	} pmtbp_mst_e;
	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_ACT = 2'b01,
		T_TURN = 2'b10
	} pmtbp_tgt_e;
	// What one end drives, each group with its enable
	typedef struct packed {
		logic [31:0] ad;
		logic ad_oe;
		logic [3:0] cbe_n;
		logic cbe_oe;
		logic frame_n;
		logic frame_oe;
		logic irdy_n;
		logic irdy_oe;
		logic trdy_n;
		logic trdy_oe;
		logic devsel_n;
		logic devsel_oe;
		logic par;
		logic par_oe;
	} pmtbp_drv_s;
	// Bus lines as the device samples them
	typedef struct packed {
		logic clk;
		logic [31:0] ad;
		logic [3:0] cbe_n;
		logic frame_n;
		logic irdy_n;
		logic trdy_n;
		logic devsel_n;
		logic gnt_n;
		logic idsel;
	} pmtbp_smp_s;
	// Byte-lane merge; enables are active low
	function automatic logic [31:0] pmtbp_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be_n);
		logic [31:0] m;
		m = o;
		for (int i = 0; i < 4; i++) begin
			if (!be_n[i]) m[8*i +: 8] = d[8*i +: 8];
		end
		return m;
	endfunction
endpackage

// [include/pmtbp_if.sv]
// Bus wires between device end and host end, with line resolution
`timescale 1ns/100ps
interface pmtbp_if;
	logic bus_clk;
	logic req_n;
	logic gnt_n;
	logic idsel;
	logic inta_n;
	pmtbp_pkg::pmtbp_drv_s d;
	pmtbp_pkg::pmtbp_drv_s h;
	logic [31:0] ad;
	logic [3:0] cbe_n;
	logic frame_n;
	logic irdy_n;
	logic trdy_n;
	logic devsel_n;
	logic par;
	// Undriven lines float high through the bus pull-ups
	assign ad = d.ad_oe ? d.ad : (h.ad_oe ? h.ad : '1);
	assign cbe_n = d.cbe_oe ? d.cbe_n : (h.cbe_oe ? h.cbe_n : '1);
	assign frame_n = d.frame_oe ? d.frame_n : (h.frame_oe ? h.frame_n : 1'b1);
	assign irdy_n = d.irdy_oe ? d.irdy_n : (h.irdy_oe ? h.irdy_n : 1'b1);
	assign trdy_n = d.trdy_oe ? d.trdy_n : (h.trdy_oe ? h.trdy_n : 1'b1);
	assign devsel_n = d.devsel_oe ? d.devsel_n : (h.devsel_oe ? h.devsel_n : 1'b1);
	assign par = d.par_oe ? d.par : (h.par_oe ? h.par : 1'b1);
	modport dev (input bus_clk, gnt_n, idsel, ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n,
		par, output d, req_n, inta_n);
	modport host (input req_n, inta_n, ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n, par,
		output bus_clk, gnt_n, idsel, h);
endinterface

// [rtl/pmtbp_lane.sv]
// Byte-lane mapper between user word order and bus order
`timescale 1ns/100ps
module pmtbp_lane (
	input wire logic big,
	input wire logic [3:0] be_i,
	input wire logic [31:0] d_i,
	output logic [3:0] be_o,
	output logic [31:0] d_o
);
	// ----------------------------------------
	// Per-byte mapping, reversed in big-endian mode
	// ----------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign be_o[i] = big ? be_i[3-i] : be_i[i];
		assign d_o[8*i +: 8] = big ? d_i[8*(3-i) +: 8] : d_i[8*i +: 8];
	end
endmodule

// [rtl/pmtbp_host.sv]
// Host end: bus clock source, arbiter, single-word initiator, memory target
`timescale 1ns/100ps
`include "pmtbp_cfg.svh"
module pmtbp_host #(
	parameter int MW = 16
) (
	input wire logic mclk,
	input wire logic nrst,
	pmtbp_if.host bus,
	input wire logic [4:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	import pmtbp_pkg::*;
	localparam int AW = $clog2(MW);
	typedef struct packed {
		logic [3:0] cnt;
		logic bclk;
		pmtbp_mst_e hst;
		logic [3:0] tmo;
		pmtbp_tgt_e tgt;
		logic [AW-1:0] t_ptr;
		logic t_wr;
		logic frame_d;
		logic gnt;
		logic go;
		logic dn;
		logic ab;
		logic [31:0] a;
		logic [31:0] wd;
		logic [31:0] ctrl;
		logic [31:0] rdv;
		pmtbp_drv_s h;
		logic gnt_n;
		logic idsel;
		logic [MW-1:0][31:0] mem;
		logic [31:0] rdata;
	} pmtbp_hst_s;
	pmtbp_hst_s r;
	pmtbp_hst_s n;
	logic edge_hit;
	logic rise;
	logic fall;

	// Bus clock from a divider; this end owns it
	assign edge_hit = (r.cnt == `PMTBP_DIV_HALF - 4'h1);
	assign rise = edge_hit & ~r.bclk;
	assign fall = edge_hit & r.bclk;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = r;
		n.cnt = edge_hit ? '0 : r.cnt + 4'h1;
		n.bclk = edge_hit ? ~r.bclk : r.bclk;
		n.rdata = '0;
		// Samples taken at the rising edge, drives change at the falling one
		if (rise) begin
			n.frame_d = bus.frame_n;
			n.gnt = !bus.req_n && (r.gnt || (r.hst == M_IDLE && !r.go));
			case (r.hst)
				M_IDLE: if (r.go && !r.gnt && bus.frame_n && bus.irdy_n && r.tgt == T_IDLE)
					n.hst = M_ADDR;
				M_ADDR: begin
					n.hst = M_DATA;
					n.tmo = '0;
				end
				M_DATA: begin
					if (!bus.devsel_n && !bus.trdy_n && !bus.irdy_n) begin
						n.rdv = bus.ad;
						n.dn = 1'b1;
						n.go = 1'b0;
						n.hst = M_TURN;
					end else if (r.tmo == `PMTBP_DSEL_TMO) begin
						n.ab = 1'b1;
						n.go = 1'b0;
						n.hst = M_TURN;
					end else begin
						n.tmo = r.tmo + 4'h1;
					end
				end
				default: n.hst = M_IDLE;
			endcase
			case (r.tgt)
				T_IDLE: if (r.frame_d && !bus.frame_n && r.hst == M_IDLE
					&& (bus.cbe_n == `PMTBP_CMD_MRD || bus.cbe_n == `PMTBP_CMD_MWR)
					&& bus.ad[31:AW+2] == `PMTBP_HBASE >> (AW + 2)) begin
					n.tgt = T_ACT;
					n.t_ptr = bus.ad[AW+1:2];
					n.t_wr = bus.cbe_n[`PMTBP_CMD_WBIT];
				end
				T_ACT: if (!bus.irdy_n) begin
					if (r.t_wr)
						n.mem[r.t_ptr] = pmtbp_merge(r.mem[r.t_ptr], bus.ad, bus.cbe_n);
					n.t_ptr = r.t_ptr + 1'b1;
					if (bus.frame_n) n.tgt = T_TURN;
				end
				default: n.tgt = T_IDLE;
			endcase
		end
		if (fall) begin
			n.gnt_n = !r.gnt;
			n.h.par_oe = 1'b0;
			n.idsel = 1'b0;
			case (r.hst)
				M_ADDR: begin
					n.h.frame_n = 1'b0;
					n.h.frame_oe = 1'b1;
					n.h.ad = r.a;
					n.h.ad_oe = 1'b1;
					n.h.cbe_n = r.ctrl[`PMTBP_HC_CMD];
					n.h.cbe_oe = 1'b1;
					n.idsel = r.ctrl[`PMTBP_HC_IDS];
				end
				M_DATA: begin
					n.h.frame_n = 1'b1;
					n.h.irdy_n = 1'b0;
					n.h.irdy_oe = 1'b1;
					n.h.cbe_n = r.ctrl[`PMTBP_HC_BE];
					n.h.ad = r.wd;
					n.h.ad_oe = r.ctrl[`PMTBP_CMD_WBIT];
				end
				M_TURN: begin
					n.h.irdy_n = 1'b1;
					n.h.ad_oe = 1'b0;
				end
				default: begin
					n.h.frame_oe = 1'b0;
					n.h.irdy_oe = 1'b0;
					n.h.cbe_oe = 1'b0;
					n.h.ad_oe = 1'b0;
				end
			endcase
			case (r.tgt)
				T_ACT: begin
					n.h.devsel_n = 1'b0;
					n.h.devsel_oe = 1'b1;
					n.h.trdy_n = 1'b0;
					n.h.trdy_oe = 1'b1;
					n.h.ad = r.mem[r.t_ptr];
					n.h.ad_oe = !r.t_wr;
				end
				T_TURN: begin
					n.h.devsel_n = 1'b1;
					n.h.trdy_n = 1'b1;
					n.h.ad_oe = 1'b0;
				end
				default: begin
					n.h.devsel_oe = 1'b0;
					n.h.trdy_oe = 1'b0;
				end
			endcase
		end
		// Register port; a start is ignored while one is pending
		if (wr) begin
			case (addr)
				`PMTBP_H_ADDR: n.a = wdata;
				`PMTBP_H_WDAT: n.wd = wdata;
				`PMTBP_H_CTRL: begin
					n.ctrl = wdata;
					if (wdata[`PMTBP_HC_GO] && !r.go && r.hst == M_IDLE) begin
						n.go = 1'b1;
						n.dn = 1'b0;
						n.ab = 1'b0;
					end
				end
				default: n.a = r.a;
			endcase
		end
		if (rd) begin
			case (addr)
				`PMTBP_H_ADDR: n.rdata = r.a;
				`PMTBP_H_WDAT: n.rdata = r.wd;
				`PMTBP_H_CTRL: n.rdata = r.ctrl;
				`PMTBP_H_STAT: n.rdata = {28'h0000000, !bus.inta_n, r.ab, r.dn,
					r.go || r.hst != M_IDLE};
				`PMTBP_H_RDAT: n.rdata = r.rdv;
				default: n.rdata = '0;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.gnt_n <= 1'b1;
			r.frame_d <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign bus.bus_clk = r.bclk;
	assign bus.gnt_n = r.gnt_n;
	assign bus.idsel = r.idsel;
	assign bus.h = r.h;
	assign rdata = r.rdata;
endmodule

// [testbench/pmtbp_props.sv]
// Checker of the bus lines between the device end and the host end
`timescale 1ns/100ps
`include "pmtbp_cfg.svh"
module pmtbp_props (
	input wire logic nrst,
	input wire logic bus_clk,
	input wire logic req_n,
	input wire logic gnt_n,
	input wire logic idsel,
	input wire logic inta_n,
	input wire pmtbp_pkg::pmtbp_drv_s d,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic devsel_n,
	input wire logic par
);
	import pmtbp_pkg::*;
	logic cfg_cmd;
	logic dev_hit;
	// Every phase opens on the bus clock rise
	default clocking cb @(posedge bus_clk);
	endclocking
	default disable iff (!nrst);
	// Config command on the lines, and the device claiming
	assign cfg_cmd = cbe_n == `PMTBP_CMD_CRD || cbe_n == `PMTBP_CMD_CWR;
	assign dev_hit = d.devsel_oe && !devsel_n;
	// ----
	// Assertions
	// ----
	chk_par_even: assert property (d.par_oe |-> par == ^{$past(ad), $past(cbe_n)})
		else $error("parity leaves an odd ones count");
	chk_par_owner: assert property ($past(nrst) |-> d.par_oe == $past(d.ad_oe))
		else $error("parity driven outside own phase");
	chk_start_grant: assert property ($rose(d.frame_oe) |-> !$past(gnt_n) && !frame_n)
		else $error("master started without grant");
	chk_req_first: assert property ($rose(d.frame_oe) |-> !$past(req_n) && req_n)
		else $error("request not low ahead of grant");
	chk_addr_cmd: assert property ($rose(d.frame_oe) |-> d.ad_oe && d.cbe_oe &&
		(cbe_n == `PMTBP_CMD_MRD || cbe_n == `PMTBP_CMD_MWR))
		else $error("address phase lacks address or command");
	chk_frame_last: assert property (d.irdy_oe && $rose(frame_n) |-> !irdy_n)
		else $error("frame released outside final phase");
	chk_cfg_claim: assert property ($fell(frame_n) && idsel && cfg_cmd |=>
		dev_hit && !trdy_n)
		else $error("selected config cycle not claimed");
	chk_cfg_refuse: assert property ($fell(frame_n) && !idsel && cfg_cmd |=> !dev_hit)
		else $error("config cycle claimed without select");
	chk_claim_late: assert property ($rose(d.devsel_oe) |-> !$past(frame_n) && !trdy_n)
		else $error("claim without frame or ready");
	chk_data_lanes: assert property (d.irdy_oe && !irdy_n |-> d.cbe_oe && d.frame_oe)
		else $error("data phase without byte enables");
	// Main scenarios reached
	cov_master: cover property ($rose(d.frame_oe));
	cov_target: cover property ($rose(d.devsel_oe));
	cov_irq: cover property ($fell(inta_n));
	cov_par: cover property (d.par_oe);
endmodule

// [testbench/tb_top.sv]
// Bench joining device and host ends, driving both user sides
`timescale 1ns/100ps
`include "pmtbp_cfg.svh"
module tb_top;
	import pmtbp_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic m_go = 1'b0;
	logic m_write = 1'b0;
	logic [31:0] m_addr = 32'h0;
	logic [3:0] m_cnt = 4'h0;
	logic [3:0] m_be_n = 4'h0;
	logic [31:0] m_wdata = 32'h0;
	logic m_busy;
	logic m_wtake;
	logic m_rvalid;
	logic [31:0] m_rdata;
	logic m_done;
	logic m_abort;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	int widx = 0;
	int k;
	logic [3:0] b;
	logic [31:0] v;
	logic [31:0] s;
	logic ab;
	logic [31:0] wbuf [16];
	logic [31:0] hmem [16];
	logic [31:0] dmem [16];
	logic [31:0] rq [$];
	logic [35:0] mon [$];
	pmtbp_if bif ();
	pmtbp_dev i_pmtbp_dev (.mclk(mclk), .nrst(nrst), .bus(bif.dev), .m_go(m_go),
		.m_write(m_write), .m_addr(m_addr), .m_cnt(m_cnt), .m_be_n(m_be_n), .m_wdata(m_wdata),
		.m_busy(m_busy), .m_wtake(m_wtake), .m_rvalid(m_rvalid), .m_rdata(m_rdata),
		.m_done(m_done), .m_abort(m_abort));
	pmtbp_host i_pmtbp_host (.mclk(mclk), .nrst(nrst), .bus(bif.host), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	pmtbp_props i_pmtbp_props (.nrst(nrst), .bus_clk(bif.bus_clk), .req_n(bif.req_n),
		.gnt_n(bif.gnt_n), .idsel(bif.idsel), .inta_n(bif.inta_n), .d(bif.d), .ad(bif.ad),
		.cbe_n(bif.cbe_n), .frame_n(bif.frame_n), .irdy_n(bif.irdy_n), .trdy_n(bif.trdy_n),
		.devsel_n(bif.devsel_n), .par(bif.par));
	// ----
	// Clock, data feed, watchers
	// ----
	always #5 mclk = ~mclk;
	// Next write word right after each take
	always @(posedge mclk) begin
		if (m_wtake === 1'b1) begin
			m_wdata <= wbuf[widx + 1];
			widx <= widx + 1;
		end
		if (m_rvalid === 1'b1) rq.push_back(m_rdata);
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			err_total++;
			final_report();
		end
	end
	// Device-master transfers; 1 ns late so no race with the edge
	always @(posedge bif.bus_clk) begin
		#1;
		if (bif.d.irdy_oe && !bif.irdy_n && !bif.trdy_n) mon.push_back({bif.cbe_n, bif.ad});
	end
	// ----
	// Expectation helpers and tasks
	// ----
	function automatic logic [31:0] swp(input logic g, input logic [31:0] x);
		return g ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
	endfunction
	function automatic logic [3:0] bsw(input logic g, input logic [3:0] x);
		return g ? {x[0], x[1], x[2], x[3]} : x;
	endfunction
	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] x,
		input logic [3:0] e);
		for (int i = 0; i < 4; i++) if (!e[i]) o[8*i +: 8] = x[8*i +: 8];
		return o;
	endfunction
	task automatic cmpw(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmpb(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic hw(input logic [4:0] a, input logic [31:0] x);
		@(posedge mclk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic hr(input logic [4:0] a, output logic [31:0] x);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 x = rdata;
	endtask
	// One host transaction, polled until idle; busy stays set if it hangs
	task automatic hcyc(input logic [3:0] c, input logic [3:0] e, input logic ids,
		input logic [31:0] a, input logic [31:0] x, output logic [31:0] st);
		int n;
		hw(`PMTBP_H_ADDR, a);
		hw(`PMTBP_H_WDAT, x);
		hw(`PMTBP_H_CTRL, {22'h0, 1'b1, ids, e, c});
		n = 0;
		st = 32'h1;
		while (st[0] !== 1'b0 && n < 400) begin
			hr(`PMTBP_H_STAT, st);
			n++;
		end
	endtask
	task automatic cfg(input logic [1:0] i, input logic [31:0] x);
		hcyc(`PMTBP_CMD_CWR, 4'h0, 1'b1, {28'h0, i, 2'h0}, x, s);
		cmpb(s[2], 1'b0);
	endtask
	task automatic mrun(input logic w, input logic [31:0] a, input logic [3:0] n,
		input logic [3:0] e);
		int t;
		rq.delete();
		mon.delete();
		@(posedge mclk);
		// A go is refused until the master has turned the bus round
		while (m_busy !== 1'b0) @(posedge mclk);
		m_go <= 1'b1;
		m_write <= w;
		m_addr <= a;
		m_cnt <= n;
		m_be_n <= e;
		m_wdata <= wbuf[0];
		widx <= 0;
		@(posedge mclk);
		m_go <= 1'b0;
		t = 0;
		do begin
			@(posedge mclk);
			#1 t++;
		end while (m_done !== 1'b1 && m_abort !== 1'b1 && t < 3000);
		ab = (m_abort === 1'b1) ? 1'b1 : (m_done === 1'b1) ? 1'b0 : 1'bx;
		// Let the read watcher take the last word before it is counted
		@(posedge mclk);
		#1;
	endtask
	// Write burst to host memory, read it back; lanes checked on the wire
	task automatic burst(input logic g, input logic [3:0] n, input logic [3:0] e);
		int o;
		logic [31:0] a;
		o = $urandom_range(16 - n);
		a = `PMTBP_HBASE + o * 4;
		for (int i = 0; i < n; i++) wbuf[i] = $urandom;
		mrun(1'b1, a, n, e);
		cmpb(ab, 1'b0);
		cmpw(32'(mon.size()), {28'h0, n});
		for (int i = 0; i < n; i++) begin
			hmem[o + i] = mrg(hmem[o + i], swp(g, wbuf[i]), bsw(g, e));
			cmpw(mrg(0, mon[i][31:0], bsw(g, e)), mrg(0, swp(g, wbuf[i]), bsw(g, e)));
			cmpw({28'h0, mon[i][35:32]}, {28'h0, bsw(g, e)});
		end
		mrun(1'b0, a, n, e);
		cmpw(32'(rq.size()), {28'h0, n});
		for (int i = 0; i < n; i++) begin
			cmpw(mon[i][31:0], hmem[o + i]);
			cmpw(mrg(0, rq[i], e), mrg(0, swp(g, hmem[o + i]), e));
		end
	endtask
	task automatic final_report();
		$display("errors=%0d compares=%0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		foreach (hmem[i]) begin
			hmem[i] = 32'h0;
			dmem[i] = 32'h0;
		end
		void'($urandom(81270));
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		// Unmapped host offset reads zero
		hr(5'h14, s);
		cmpw(s, 32'h0);
		// Base reset value, and a config cycle without select
		hcyc(`PMTBP_CMD_CRD, 4'h0, 1'b1, 32'hC, 32'h0, s);
		hr(`PMTBP_H_RDAT, s);
		cmpw(s, `PMTBP_BASE_RST);
		hcyc(`PMTBP_CMD_CRD, 4'h0, 1'b0, 32'hC, 32'h0, s);
		cmpb(s[2], 1'b1);
		// Target memory: partial lanes, then one word past the window
		for (int i = 0; i < 8; i++) begin
			k = $urandom_range(15);
			b = (i == 0) ? 4'h0 : 4'($urandom_range(14));
			v = $urandom;
			hcyc(`PMTBP_CMD_MWR, b, 1'b0, `PMTBP_BASE_RST + k * 4, v, s);
			cmpb(s[2], 1'b0);
			dmem[k] = mrg(dmem[k], v, b);
			hcyc(`PMTBP_CMD_MRD, 4'h0, 1'b0, `PMTBP_BASE_RST + k * 4, 32'h0, s);
			hr(`PMTBP_H_RDAT, s);
			cmpw(s, dmem[k]);
		end
		hcyc(`PMTBP_CMD_MWR, 4'h0, 1'b0, `PMTBP_BASE_RST + 32'h40, v, s);
		cmpb(s[2], 1'b1);
		// Interrupt from pending target write: mask, enable, clear
		cfg(2'h1, 32'h4);
		cfg(2'h0, 32'h2);
		cmpb(bif.inta_n, 1'b0);
		hr(`PMTBP_H_STAT, s);
		cmpb(s[3], 1'b1);
		cfg(2'h1, 32'h0);
		cmpb(bif.inta_n, 1'b1);
		cfg(2'h1, 32'h4);
		cmpb(bif.inta_n, 1'b0);
		cfg(2'h2, 32'h7);
		cmpb(bif.inta_n, 1'b1);
		// Bursts: longest, shortest, random; little then big lanes
		for (int i = 0; i < 8; i++) begin
			if (i == 4) cfg(2'h0, 32'h3);
			b = 4'($urandom_range(14));
			k = (i % 4 == 0) ? 15 : (i % 4 == 1) ? 1 : $urandom_range(15, 1);
			burst(i >= 4, 4'(k), b);
		end
		// Nobody claims this address
		mrun(1'b1, 32'h4000_0000, 4'h1, 4'h0);
		cmpb(ab, 1'b1);
		final_report();
	end
endmodule
